/* src/mem_select_regs.svh */
`ifndef MEM_SELECT_REGS_SVH
`define MEM_SELECT_REGS_SVH

// ****************************************************************
// Clock and timing figures, in nanoseconds and in clock cycles.
// ****************************************************************

`define CLK_PERIOD_NS     8
`define STATE_TIME_NS     1000
`define MID_START_NS      333
`define MID_LEN_NS        222
`define END_LEN_NS        222
`define READ_PORTION_NS   400
`define WRITE_PORTION_NS  400

// Least times round up to whole cycles; the state time rounds down.
`define STATE_TIME_CYC    (`STATE_TIME_NS / `CLK_PERIOD_NS)
`define MID_START_CYC     ((`MID_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MID_LEN_CYC       ((`MID_LEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define END_LEN_CYC       ((`END_LEN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_CYC          ((`READ_PORTION_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_CYC         ((`WRITE_PORTION_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************************************
// Forced digits for the protected area and the error-save area, and the last BCD digit.
// ****************************************************************

`define PROTECT_HUNDREDS  4'h1
`define ERROR_SAVE_TENS   4'h4
`define BCD_LAST_DIGIT    4'h9

`endif

/* src/mem_select_pkg.sv */
package mem_select_pkg;

  // ****************************************************************
  // Carrier types.
  // ****************************************************************

  // Digits of the result bus, all BCD.
  typedef struct packed {
    logic [3:0] hundreds;
    logic [3:0] tens;
    logic [3:0] units;
  } result_bus_t;

  // One-of-ten driver selects for both axes.
  typedef struct packed {
    logic [9:0] y_source_sel;
    logic [9:0] y_sink_sel;
    logic [9:0] x_source_sel;
    logic [9:0] x_sink_sel;
  } drive_sel_t;

  // Y driver portion strobes.
  typedef struct packed {
    logic y_read_source_strobe;
    logic y_read_sink_strobe;
    logic y_write_source_strobe;
    logic y_write_sink_strobe;
  } strobe_t;

  // Portions of one memory cycle.
  typedef enum logic [1:0] {
    MEM_IDLE,
    MEM_READ,
    MEM_WRITE
  } mem_phase_t;

  // Whole state of the select and timing block.
  typedef struct packed {
    mem_phase_t  phase;
    logic [6:0]  mem_cnt;
    logic        wr_pend;
    result_bus_t addr;
    logic [3:0]  thousands;
    logic [6:0]  state_cnt;
    drive_sel_t  sel;
    strobe_t     strb;
    logic        mid;
    logic        fin;
    logic        busy;
  } sel_state_t;

endpackage : mem_select_pkg

/* src/bcd_one_of_ten.sv */
`timescale 1ns/1ps
`default_nettype none

module bcd_one_of_ten (
  input  wire logic       enable,
  input  wire logic [3:0] digit,
  output logic      [9:0] sel
);

  // ****************************************************************
  // Decoder.
  // ****************************************************************

  // A digit above nine selects nothing, so no driver pair is hit.
  always_comb begin
    sel = 10'h000;
    if (enable && (digit <= 4'h9)) begin
      sel[digit] = 1'b1;
    end
  end

endmodule : bcd_one_of_ten

`default_nettype wire

/* src/core_memory_select_timing.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mem_select_regs.svh"

module core_memory_select_timing
  import mem_select_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        mem_start,
  input  wire logic        write_cmd,
  input  wire result_bus_t rbus_in,
  input  wire logic [3:0]  base_thousands,
  input  wire logic        hundreds_force,
  input  wire logic        error_save,
  output result_bus_t      addr_bus_out,
  output drive_sel_t       drive_sel,
  output strobe_t          strobes,
  output logic             mid_state_pulse,
  output logic             end_state_pulse,
  output logic             mem_busy
);

  // ****************************************************************
  // State and next-address path.
  // ****************************************************************

  sel_state_t  st_ff;
  sel_state_t  nxt_st;
  logic        accept;
  logic        nxt_active;
  result_bus_t nxt_addr;
  logic [3:0]  nxt_thousands;
  drive_sel_t  nxt_sel;

  // A new cycle is taken only while the previous one has ended.
  assign accept = mem_start && (st_ff.phase == MEM_IDLE);

  // Forced digits override the result bus when a cycle is taken.
  always_comb begin
    nxt_addr      = st_ff.addr;
    nxt_thousands = st_ff.thousands;
    if (accept) begin
      nxt_addr      = rbus_in;
      nxt_thousands = base_thousands;
      if (hundreds_force) begin
        nxt_addr.hundreds = `PROTECT_HUNDREDS;
      end
      if (error_save) begin
        nxt_addr.tens = `ERROR_SAVE_TENS;
      end
    end
  end

  // ****************************************************************
  // Driver select decoders.
  // ****************************************************************

  // Selects stand for the whole memory cycle and are low when idle.
  assign nxt_active = accept || (st_ff.phase != MEM_IDLE &&
                      !(st_ff.mem_cnt == 7'h00 &&
                        (st_ff.phase == MEM_WRITE || !st_ff.wr_pend)));

  bcd_one_of_ten u_dec_y_src (
    .enable (nxt_active),
    .digit  (nxt_addr.hundreds),
    .sel    (nxt_sel.y_source_sel)
  );

  bcd_one_of_ten u_dec_y_snk (
    .enable (nxt_active),
    .digit  (nxt_thousands),
    .sel    (nxt_sel.y_sink_sel)
  );

  bcd_one_of_ten u_dec_x_src (
    .enable (nxt_active),
    .digit  (nxt_addr.units),
    .sel    (nxt_sel.x_source_sel)
  );

  bcd_one_of_ten u_dec_x_snk (
    .enable (nxt_active),
    .digit  (nxt_addr.tens),
    .sel    (nxt_sel.x_sink_sel)
  );

  // ****************************************************************
  // Next state.
  // ****************************************************************

  // Memory cycle sequencer plus the free-running state-time counter.
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.addr      = nxt_addr;
    nxt_st.thousands = nxt_thousands;
    unique case (st_ff.phase)
      MEM_IDLE: begin
        if (accept) begin
          nxt_st.phase   = MEM_READ;
          nxt_st.mem_cnt = 7'(`READ_CYC - 1);
          nxt_st.wr_pend = write_cmd;
        end
      end
      MEM_READ: begin
        if (st_ff.mem_cnt != 7'h00) begin
          nxt_st.mem_cnt = st_ff.mem_cnt - 7'h01;
        end else if (st_ff.wr_pend) begin
          nxt_st.phase   = MEM_WRITE;
          nxt_st.mem_cnt = 7'(`WRITE_CYC - 1);
        end else begin
          nxt_st.phase = MEM_IDLE;
        end
      end
      MEM_WRITE: begin
        if (st_ff.mem_cnt != 7'h00) begin
          nxt_st.mem_cnt = st_ff.mem_cnt - 7'h01;
        end else begin
          nxt_st.phase   = MEM_IDLE;
          nxt_st.wr_pend = 1'b0;
        end
      end
      default: begin
        nxt_st.phase = MEM_IDLE;
      end
    endcase

    // Portion strobes follow the phase that is entered.
    nxt_st.strb.y_read_source_strobe  = (nxt_st.phase == MEM_READ);
    nxt_st.strb.y_read_sink_strobe    = (nxt_st.phase == MEM_READ);
    nxt_st.strb.y_write_source_strobe = (nxt_st.phase == MEM_WRITE);
    nxt_st.strb.y_write_sink_strobe   = (nxt_st.phase == MEM_WRITE);
    nxt_st.sel  = nxt_sel;
    nxt_st.busy = (nxt_st.phase != MEM_IDLE);

    // State-time counter wraps at the interval length.
    if (st_ff.state_cnt == 7'(`STATE_TIME_CYC - 1)) begin
      nxt_st.state_cnt = 7'h00;
    end else begin
      nxt_st.state_cnt = st_ff.state_cnt + 7'h01;
    end
    nxt_st.mid = (nxt_st.state_cnt >= 7'(`MID_START_CYC)) &&
                 (nxt_st.state_cnt <
                  7'(`MID_START_CYC + `MID_LEN_CYC));
    nxt_st.fin = (nxt_st.state_cnt >=
                  7'(`STATE_TIME_CYC - `END_LEN_CYC));
  end

  // State register.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Every output is a field of the state register.
  assign addr_bus_out    = st_ff.addr;
  assign drive_sel       = st_ff.sel;
  assign strobes         = st_ff.strb;
  assign mid_state_pulse = st_ff.mid;
  assign end_state_pulse = st_ff.fin;
  assign mem_busy        = st_ff.busy;

  // ****************************************************************
  // Assertions.
  // ****************************************************************

  localparam int MID_ON  = `MID_START_CYC;
  localparam int MID_OFF = `MID_START_CYC + `MID_LEN_CYC;
  localparam int END_ON  = `STATE_TIME_CYC - `END_LEN_CYC;
  localparam int LAST    = `STATE_TIME_CYC - 1;
  localparam int RD_CYC  = `READ_CYC;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_take_read_only;
    mem_start && !mem_busy && !write_cmd;
  endsequence

  sequence s_take_forced;
    mem_start && !mem_busy && hundreds_force;
  endsequence

  sequence s_take_saved;
    mem_start && !mem_busy && error_save;
  endsequence

  a_mid_rise_time: assert property (
    $rose(mid_state_pulse) |-> st_ff.state_cnt == 7'(MID_ON))
    else $error("mid pulse rose at the wrong time");

  a_mid_fall_time: assert property (
    $fell(mid_state_pulse) |-> st_ff.state_cnt == 7'(MID_OFF))
    else $error("mid pulse fell at the wrong time");

  a_end_rise_time: assert property (
    $rose(end_state_pulse) |-> st_ff.state_cnt == 7'(END_ON))
    else $error("end pulse rose at the wrong time");

  a_end_wrap_clear: assert property (
    end_state_pulse && st_ff.state_cnt == 7'(LAST) |=> !end_state_pulse)
    else $error("end pulse ran past the state interval");

  a_portion_excl: assert property (
    !((strobes.y_read_source_strobe || strobes.y_read_sink_strobe) &&
      (strobes.y_write_source_strobe || strobes.y_write_sink_strobe)))
    else $error("read and write strobes overlap");

  a_write_after_read: assert property (
    $rose(strobes.y_write_source_strobe)
    |-> $past(strobes.y_read_source_strobe))
    else $error("write portion not preceded by read");

  // The read strobe still stands on the last read cycle, and a read-only
  // cycle is fully over one cycle later, with no write portion.
  a_no_write_cmd: assert property (
    s_take_read_only |-> ##RD_CYC strobes.y_read_source_strobe
    ##1 (!mem_busy && !strobes.y_write_source_strobe
         && !strobes.y_write_sink_strobe))
    else $error("write portion without write command");

  a_write_pair: assert property (
    strobes.y_write_sink_strobe == strobes.y_write_source_strobe)
    else $error("write sink and source strobes disagree");

  a_read_pair: assert property (
    strobes.y_read_sink_strobe == strobes.y_read_source_strobe)
    else $error("read sink and source strobes disagree");

  a_hundreds_force: assert property (
    s_take_forced
    |=> addr_bus_out.hundreds == `PROTECT_HUNDREDS
        && drive_sel.y_source_sel == 10'h002)
    else $error("hundreds force not applied");

  a_error_save: assert property (
    s_take_saved
    |=> addr_bus_out.tens == `ERROR_SAVE_TENS
        && drive_sel.x_sink_sel == 10'h010)
    else $error("error save tens not applied");

  a_y_source_dec: assert property (
    mem_busy && addr_bus_out.hundreds <= `BCD_LAST_DIGIT
    |-> $onehot(drive_sel.y_source_sel)
        && drive_sel.y_source_sel[addr_bus_out.hundreds])
    else $error("Y source select does not match hundreds");

  a_y_sink_dec: assert property (
    mem_start && !mem_busy && base_thousands <= `BCD_LAST_DIGIT
    |=> $onehot(drive_sel.y_sink_sel)
        && drive_sel.y_sink_sel[$past(base_thousands)])
    else $error("Y sink select does not match thousands");

  a_x_source_dec: assert property (
    mem_busy && addr_bus_out.units <= `BCD_LAST_DIGIT
    |-> $onehot(drive_sel.x_source_sel)
        && drive_sel.x_source_sel[addr_bus_out.units])
    else $error("X source select does not match units");

endmodule : core_memory_select_timing

`default_nettype wire

/* sim/y_driver_stage.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Y driver stage of the core memory module.
// ****************************************************************

module y_driver_stage
  import mem_select_pkg::*;
(
  input  wire drive_sel_t drive_sel,
  input  wire strobe_t    strobes,
  output logic [9:0]      y_write_source_out,
  output logic [9:0]      y_sink_drive_out,
  output logic [9:0]      y_read_source_out
);
  logic any_sink;

  // A driver conducts only while its strobe enables the whole group.
  assign any_sink = strobes.y_write_sink_strobe
                  | strobes.y_read_sink_strobe;
  assign y_write_source_out = {10{strobes.y_write_source_strobe}}
                            & drive_sel.y_source_sel;
  assign y_sink_drive_out = {10{any_sink}} & drive_sel.y_sink_sel;
  assign y_read_source_out = {10{strobes.y_read_source_strobe}}
                           & drive_sel.y_source_sel;
endmodule : y_driver_stage

`default_nettype wire

/* sim/core_memory_select_timing_bench.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Bench for the memory select and state timing block.
// ****************************************************************

module core_memory_select_timing_bench;
  import mem_select_pkg::*;
  logic        core_clk, rst, mem_start, write_cmd;
  logic        hundreds_force, error_save;
  logic        mid_state_pulse, end_state_pulse, mem_busy;
  logic [3:0]  base_thousands;
  logic [9:0]  wsrc, sink, rsrc;
  result_bus_t rbus_in, addr_bus_out;
  drive_sel_t  drive_sel;
  strobe_t     strobes;
  int          failures, checks_done, tc;

  core_memory_select_timing core_memory_select_timing_i (
    .core_clk(core_clk), .rst(rst), .mem_start(mem_start),
    .write_cmd(write_cmd), .rbus_in(rbus_in),
    .base_thousands(base_thousands), .hundreds_force(hundreds_force),
    .error_save(error_save), .addr_bus_out(addr_bus_out),
    .drive_sel(drive_sel), .strobes(strobes),
    .mid_state_pulse(mid_state_pulse), .end_state_pulse(end_state_pulse),
    .mem_busy(mem_busy));

  y_driver_stage y_driver_stage_i (
    .drive_sel(drive_sel), .strobes(strobes), .y_write_source_out(wsrc),
    .y_sink_drive_out(sink), .y_read_source_out(rsrc));

  // Free running clock of 8 ns.
  always #4 core_clk = ~core_clk;

  // One-hot select expected for a digit; non-BCD selects nothing.
  function automatic logic [9:0] oh(input logic [3:0] d);
    return (d <= 4'h9) ? (10'h001 << d) : 10'h000;
  endfunction : oh

  // Random BCD address digits.
  function automatic result_bus_t rnd_bus();
    return result_bus_t'{4'($urandom_range(0, 9)),
                         4'($urandom_range(0, 9)),
                         4'($urandom_range(0, 9))};
  endfunction : rnd_bus

  // Counts every comparison and reports a mismatch at once.
  task automatic check(input logic ok, input string what);
    checks_done++;
    if (!ok) begin
      failures++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic close_out();
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // ****************************************************************
  // State interval timing, checked over the whole run.
  // ****************************************************************

  // Mirrors the 125 cycle state interval position.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tc <= 0;
    end else begin
      tc <= (tc == 124) ? 0 : tc + 1;
    end
  end

  // Compares both pulses mid-cycle, where they are settled.
  always @(negedge core_clk) begin
    if (!rst) begin
      check(mid_state_pulse === (tc >= 42 && tc < 70), "mid pulse");
      check(end_state_pulse === (tc >= 97), "end pulse");
    end
  end

  // ****************************************************************
  // One memory cycle, with a refused request in the read portion.
  // ****************************************************************

  task automatic mem_cycle(input logic wr, input result_bus_t rb,
                           input logic [3:0] th, input logic hf,
                           input logic es);
    result_bus_t ea;
    logic        rd, wp, bz;
    drive_sel_t  sel;
    int          last;
    ea = rb;
    last = wr ? 101 : 51;
    if (hf) ea.hundreds = 4'h1;
    if (es) ea.tens = 4'h4;
    mem_start = 1'b1;
    write_cmd = wr;
    rbus_in = rb;
    base_thousands = th;
    hundreds_force = hf;
    error_save = es;
    for (int j = 1; j <= last; j++) begin
      @(posedge core_clk);
      #1;
      if (j == 1 || j == 10 || j == 11) mem_start = (j == 10);
      if (j == 10) rbus_in = rnd_bus();
      if (j == 10) write_cmd = ~wr;
      rd = (j <= 50);
      wp = wr && j > 50 && j <= 100;
      bz = rd || wp;
      sel = bz ? drive_sel_t'{oh(ea.hundreds), oh(th), oh(ea.units),
                              oh(ea.tens)} : '0;
      check(mem_busy === bz, "busy");
      check(strobes === strobe_t'{rd, rd, wp, wp}, "strobes");
      check(drive_sel === sel, "selects");
      check(addr_bus_out === ea, "address");
      check(wsrc === (wp ? oh(ea.hundreds) : 10'h000), "wr src");
      check(sink === (bz ? oh(th) : 10'h000), "sink");
      check(rsrc === (rd ? oh(ea.hundreds) : 10'h000), "rd src");
    end
  endtask : mem_cycle

  // ****************************************************************
  // Main sequence and watchdog.
  // ****************************************************************

  // Resets, runs corner cases, then random back-to-back cycles.
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    mem_start = 1'b0;
    write_cmd = 1'b0;
    rbus_in = '0;
    base_thousands = 4'h0;
    hundreds_force = 1'b0;
    error_save = 1'b0;
    failures = 0;
    checks_done = 0;
    void'($urandom(32'h3dd2_3c1c));
    repeat (4) @(posedge core_clk);
    #1;
    rst = 1'b0;
    mem_cycle(1'b1, result_bus_t'{4'h5, 4'h3, 4'h7}, 4'h2, 1'b0, 1'b0);
    mem_cycle(1'b0, result_bus_t'{4'h9, 4'h0, 4'h9}, 4'h9, 1'b1, 1'b1);
    mem_cycle(1'b1, result_bus_t'{4'h0, 4'h9, 4'h0}, 4'h0, 1'b0, 1'b1);
    mem_cycle(1'b0, result_bus_t'{4'h3, 4'h3, 4'h3}, 4'ha, 1'b1, 1'b0);
    repeat (8) begin
      mem_cycle(1'($urandom_range(0, 1)), rnd_bus(),
                4'($urandom_range(0, 9)), 1'($urandom_range(0, 1)),
                1'($urandom_range(0, 1)));
    end
    close_out();
  end

  // Cuts a hang short well beyond the expected 1116 cycles at most.
  initial begin
    #(8 * 5000);
    failures++;
    close_out();
  end
endmodule : core_memory_select_timing_bench

`default_nettype wire
